// ==== logic/flash_pd_id.sv ====
// power-down entry, release and identification command interpreter
`timescale 1ns/100ps
module flash_pd_id #(
	parameter logic [7:0] MAKER_CODE    = 8'h5a, // arbitrary value
	parameter logic [7:0] DEVICE_CODE   = 8'h11, // arbitrary value
	parameter logic [7:0] MEM_TYPE_CODE = 8'h31, // arbitrary value
	parameter logic [7:0] CAPACITY_CODE = 8'h12  // arbitrary value
) (
	// clock and reset
	input  wire logic i_sys_clk,
	input  wire logic i_rstn,
	// spi pins, sampled as synchronous
	input  wire logic i_cs_n,
	input  wire logic i_sclk,
	input  wire logic i_serial_in,
	// internal write cycle in progress
	input  wire logic i_busy,
	// serial out and its enable (low while driving)
	output logic      o_serial_out,
	output logic      o_serial_out_oe_n,
	// status
	output logic      o_deep_sleep,
	output logic      o_ready
);
	typedef enum logic [4:0] {
		ST_OPCODE = 5'h01,
		ST_PARAM  = 5'h02,
		ST_SHIFT  = 5'h04,
		ST_IGNORE = 5'h08,
		ST_SPARE  = 5'h10
	} phase_e;
	typedef enum logic [3:0] {
		PW_STANDBY  = 4'h1,
		PW_ENTERING = 4'h2,
		PW_SLEEP    = 4'h4,
		PW_WAKING   = 4'h8
	} power_e;

	phase_e                          phase, next_phase;
	power_e                          power, next_power;
	logic [7:0]                      opcode, next_opcode;
	logic [5:0]                      bit_cnt, next_bit_cnt;
	logic [flash_pd_id_pkg::TIMER_W-1:0] dwell, next_dwell;
	logic [23:0]                     out_word, next_out_word;
	logic [4:0]                      out_len, next_out_len;
	logic [4:0]                      out_idx, next_out_idx;
	logic                            sout, next_sout;
	logic                            soe_n, next_soe_n;
	logic [flash_pd_id_pkg::TIMER_W-1:0] timer, next_timer;
	logic                            sclk_q, cs_q;
	logic                            rise, fall, cs_rise;

	// edge detect on pins taken as synchronous
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			sclk_q <= 1'b0;
			cs_q   <= 1'b1;
		end else begin
			sclk_q <= i_sclk;
			cs_q   <= i_cs_n;
		end
	end
	assign rise    = i_sclk & ~sclk_q & ~i_cs_n;
	assign fall    = ~i_sclk & sclk_q & ~i_cs_n;
	assign cs_rise = i_cs_n & ~cs_q;

	// command decode, shifting and power state
	always_comb begin
		next_phase    = phase;
		next_power    = power;
		next_opcode   = opcode;
		next_bit_cnt  = bit_cnt;
		next_out_word = out_word;
		next_out_len  = out_len;
		next_out_idx  = out_idx;
		next_sout     = sout;
		next_soe_n    = soe_n;
		next_timer    = timer;
		// entry and wake timers run down; the host keeps select high meanwhile
		if (timer != '0)
			next_timer = timer - 1'b1;
		if (power == PW_ENTERING && timer == '0)
			next_power = PW_SLEEP;
		if (power == PW_WAKING && timer == '0)
			next_power = PW_STANDBY;
		if (rise) begin
			case (phase)
				ST_OPCODE: begin
					next_opcode  = {opcode[6:0], i_serial_in};
					next_bit_cnt = bit_cnt + 6'h01;
					if (bit_cnt == 6'(flash_pd_id_pkg::OPCODE_BITS - 1)) begin
						next_bit_cnt = '0;
						next_phase   = ST_IGNORE;
						if (i_busy || power == PW_ENTERING || power == PW_WAKING) begin
							next_phase = ST_IGNORE;
						end else if (power == PW_SLEEP) begin
							if ({opcode[6:0], i_serial_in} ==
									flash_pd_id_pkg::WAKE_AND_READ_PART_CODE_CMD)
								next_phase = ST_PARAM;
						end else begin
							case ({opcode[6:0], i_serial_in})
								flash_pd_id_pkg::WAKE_AND_READ_PART_CODE_CMD,
								flash_pd_id_pkg::READ_MAKER_DEVICE_CMD:
									next_phase = ST_PARAM;
								flash_pd_id_pkg::DEEP_SLEEP_CMD:
									next_phase = ST_PARAM; // waits for select
								flash_pd_id_pkg::READ_THREE_BYTE_IDENT_CMD: begin
									next_phase    = ST_SHIFT;
									next_out_word = {MAKER_CODE, MEM_TYPE_CODE,
										CAPACITY_CODE};
									next_out_len  = 5'd23;
									next_out_idx  = 5'd23;
								end
								default: next_phase = ST_IGNORE;
							endcase
						end
					end
				end
				ST_PARAM: begin
					next_bit_cnt = bit_cnt + 6'h01;
					if (opcode == flash_pd_id_pkg::DEEP_SLEEP_CMD)
						next_phase = ST_IGNORE; // extra bit cancels
					if (bit_cnt == 6'(flash_pd_id_pkg::ADDR_BITS - 1)) begin
						next_phase   = ST_SHIFT;
						next_out_len = 5'd15;
						next_out_idx = 5'd15;
						if (opcode == flash_pd_id_pkg::WAKE_AND_READ_PART_CODE_CMD) begin
							next_out_word = {16'h0000, DEVICE_CODE};
							next_out_len  = 5'd7;
							next_out_idx  = 5'd7;
						end else if (i_serial_in)
							next_out_word = {8'h00, DEVICE_CODE, MAKER_CODE};
						else
							next_out_word = {8'h00, MAKER_CODE, DEVICE_CODE};
					end
				end
				default: ;
			endcase
		end
		// output on falling edges, repeating the pattern
		if (fall && phase == ST_SHIFT) begin
			next_sout  = out_word[out_idx];
			next_soe_n = 1'b0;
			next_out_idx = (out_idx == '0) ? out_len : out_idx - 1'b1;
		end
		// select rising ends every command
		if (cs_rise) begin
			next_phase   = ST_OPCODE;
			next_bit_cnt = '0;
			next_soe_n   = 1'b1;
			if (phase == ST_PARAM && opcode == flash_pd_id_pkg::DEEP_SLEEP_CMD &&
					bit_cnt == '0 && !i_busy) begin
				next_power = PW_ENTERING;
				next_timer = flash_pd_id_pkg::TIMER_W'(
					flash_pd_id_pkg::SLEEP_ENTRY_CYCLES);
			end
			if (opcode == flash_pd_id_pkg::WAKE_AND_READ_PART_CODE_CMD &&
					(phase == ST_PARAM || phase == ST_SHIFT)) begin
				if (power == PW_SLEEP) begin
					next_power = PW_WAKING;
					next_timer = (phase == ST_SHIFT || bit_cnt != '0) ?
						flash_pd_id_pkg::TIMER_W'(flash_pd_id_pkg::WAKE_CODE_CYCLES) :
						flash_pd_id_pkg::TIMER_W'(flash_pd_id_pkg::WAKE_SHORT_CYCLES);
				end
				// awake: already standby, nothing to wait for
			end
		end
		if (i_cs_n && phase != ST_OPCODE)
			next_phase = ST_OPCODE;
	end

	// state registers; reset lands in standby
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			phase    <= ST_OPCODE;
			power    <= PW_STANDBY;
			opcode   <= 8'h00;
			bit_cnt  <= 6'h00;
			out_word <= 24'h000000;
			out_len  <= 5'h00;
			out_idx  <= 5'h00;
			sout     <= 1'b0;
			soe_n    <= 1'b1;
			timer    <= '0;
		end else begin
			phase    <= next_phase;
			power    <= next_power;
			opcode   <= next_opcode;
			bit_cnt  <= next_bit_cnt;
			out_word <= next_out_word;
			out_len  <= next_out_len;
			out_idx  <= next_out_idx;
			sout     <= next_sout;
			soe_n    <= next_soe_n;
			timer    <= next_timer;
		end
	end

	assign o_serial_out      = sout;
	assign o_serial_out_oe_n = soe_n;
	assign o_deep_sleep      = (power == PW_SLEEP);
	assign o_ready           = (power == PW_STANDBY);

	// cycles spent in the present power state; only the delay checks read it,
	// and it saturates so a long standby cannot wrap it into a false match
	always_comb begin
		next_dwell = dwell;
		if (next_power != power)
			next_dwell = '0;
		else if (dwell != '1)
			next_dwell = dwell + 1'b1;
	end

	// dwell register
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn)
			dwell <= '0;
		else
			dwell <= next_dwell;
	end

	// checks
	property p_reset_standby;
		@(posedge i_sys_clk) !i_rstn |=> (power == PW_STANDBY);
	endproperty
	a_reset_standby: assert property (p_reset_standby)
		else $error("no standby after reset");
	property p_sleep_only_from_entry;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		$rose(power == PW_SLEEP) |-> $past(power) == PW_ENTERING;
	endproperty
	a_sleep_only_from_entry: assert property (p_sleep_only_from_entry)
		else $error("bad sleep entry");
	property p_sleep_stays;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		(power == PW_SLEEP) && !cs_rise |=> (power == PW_SLEEP);
	endproperty
	a_sleep_stays: assert property (p_sleep_stays)
		else $error("sleep left without select");
	property p_entry_delay;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		$rose(power == PW_ENTERING) |-> (power == PW_ENTERING)[*8];
	endproperty
	a_entry_delay: assert property (p_entry_delay)
		else $error("entry delay too short");
	property p_busy_no_entry;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		cs_rise && i_busy && power == PW_STANDBY |=> power == PW_STANDBY;
	endproperty
	a_busy_no_entry: assert property (p_busy_no_entry)
		else $error("sleep while busy");
	property p_wake_ends;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		$rose(power == PW_WAKING) |-> ##[1:400] power == PW_STANDBY;
	endproperty
	a_wake_ends: assert property (p_wake_ends)
		else $error("wake did not finish");
	property p_quiet_deselected;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		cs_rise |=> soe_n;
	endproperty
	a_quiet_deselected: assert property (p_quiet_deselected)
		else $error("output after select");
	property p_drive_on_fall;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		$changed(sout) |-> $past(fall);
	endproperty
	a_drive_on_fall: assert property (p_drive_on_fall)
		else $error("output moved off falling edge");
	// delay lengths measured against the package counts, not the timer itself
	property p_entry_length;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		power == PW_ENTERING && next_power == PW_SLEEP |->
			dwell == flash_pd_id_pkg::TIMER_W'(flash_pd_id_pkg::SLEEP_ENTRY_CYCLES);
	endproperty
	a_entry_length: assert property (p_entry_length)
		else $error("entry delay length wrong");
	property p_wake_length;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		power == PW_WAKING && next_power == PW_STANDBY |->
			dwell == flash_pd_id_pkg::TIMER_W'(flash_pd_id_pkg::WAKE_SHORT_CYCLES) ||
			dwell == flash_pd_id_pkg::TIMER_W'(flash_pd_id_pkg::WAKE_CODE_CYCLES);
	endproperty
	a_wake_length: assert property (p_wake_length)
		else $error("wake delay length wrong");
	property p_busy_opcode_ignored;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		rise && phase == ST_OPCODE && i_busy &&
			bit_cnt == 6'(flash_pd_id_pkg::OPCODE_BITS - 1) |=> phase == ST_IGNORE;
	endproperty
	a_busy_opcode_ignored: assert property (p_busy_opcode_ignored)
		else $error("opcode decoded while busy");
	property p_asleep_refuses;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		rise && phase == ST_OPCODE && power == PW_SLEEP &&
			bit_cnt == 6'(flash_pd_id_pkg::OPCODE_BITS - 1) &&
			{opcode[6:0], i_serial_in} != flash_pd_id_pkg::WAKE_AND_READ_PART_CODE_CMD
			|=> phase == ST_IGNORE;
	endproperty
	a_asleep_refuses: assert property (p_asleep_refuses)
		else $error("opcode decoded while asleep");
	property p_out_only_shifting;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		!soe_n |-> phase == ST_SHIFT;
	endproperty
	a_out_only_shifting: assert property (p_out_only_shifting)
		else $error("output driven outside a read");
	property p_awake_wake_at_once;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		cs_rise && power == PW_STANDBY &&
			opcode == flash_pd_id_pkg::WAKE_AND_READ_PART_CODE_CMD |=> power == PW_STANDBY;
	endproperty
	a_awake_wake_at_once: assert property (p_awake_wake_at_once)
		else $error("awake release did not stay in standby");
	property p_ident_loaded;
		@(posedge i_sys_clk) disable iff (!i_rstn)
		rise && phase == ST_OPCODE && power == PW_STANDBY && !i_busy &&
			bit_cnt == 6'(flash_pd_id_pkg::OPCODE_BITS - 1) &&
			{opcode[6:0], i_serial_in} == flash_pd_id_pkg::READ_THREE_BYTE_IDENT_CMD
			|=> phase == ST_SHIFT && out_word == {MAKER_CODE, MEM_TYPE_CODE, CAPACITY_CODE};
	endproperty
	a_ident_loaded: assert property (p_ident_loaded)
		else $error("ident read not loaded");
endmodule : flash_pd_id

// ==== logic/flash_pd_id_pkg.sv ====
// package of opcodes, bit counts and timing for the power-down and id command block
// Summary of operation
// - only sleep opcode enters deep sleep
// - in deep sleep ignore all but wake
// - select high gives standby when idle
// - reset always lands in standby
// - sleep executes only if select rises after bit eight
// - wait entry delay before sleeping
// - sleep rejected while busy cycle runs
// - short wake delay after bare wake
// - wake plus three dummies shifts device code
// - device code repeats until select rises
// - wake from sleep takes long delay
// - wake when awake gives standby at once
// - wake works awake; ignored while busy
// - code read address zero: maker then device
// - address one: device then maker
// - ident read: maker, type, capacity bytes
// - select high ends ident read to standby
// - ident ignored while erase or program
// - sample on rising, drive on falling
package flash_pd_id_pkg;
	localparam logic [7:0] DEEP_SLEEP_CMD              = 8'hb9;
	localparam logic [7:0] WAKE_AND_READ_PART_CODE_CMD = 8'hab;
	localparam logic [7:0] READ_MAKER_DEVICE_CMD       = 8'h90;
	localparam logic [7:0] READ_THREE_BYTE_IDENT_CMD   = 8'h9f;
	// bit counts of each command phase
	localparam int OPCODE_BITS  = 8;
	localparam int DUMMY_BITS   = 24;
	localparam int ADDR_BITS    = 24;
	// timing in ns and cycles at 100 MHz
	localparam int CLK_PERIOD_NS             = 10;
	localparam int SLEEP_ENTRY_DELAY_NS      = 3000;
	localparam int WAKE_DELAY_SHORT_NS       = 3000;
	localparam int WAKE_DELAY_WITH_CODE_NS   = 1800;
	localparam int SLEEP_ENTRY_CYCLES =
		(SLEEP_ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WAKE_SHORT_CYCLES =
		(WAKE_DELAY_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WAKE_CODE_CYCLES =
		(WAKE_DELAY_WITH_CODE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TIMER_W = 16;
endpackage : flash_pd_id_pkg

// ==== bench/spi_host_model.sv ====
// spi host model driving select, clock and data into the flash block
`timescale 1ns/100ps
module spi_host_model (
	// system clock used to pace the serial clock
	input  wire logic i_sys_clk,
	// spi pins toward the device
	output logic      o_cs_n,
	output logic      o_sclk,
	output logic      o_mosi,
	// device serial out
	input  wire logic i_miso
);
	// idle: deselected, clock parked low
	initial begin
		o_cs_n = 1'b1;
		o_sclk = 1'b0;
		o_mosi = 1'b0;
	end

	// each clock level held four sys clocks, above the one the device needs
	task automatic clk_bit(input logic b, output logic r);
		o_mosi = b;
		repeat (4) @(posedge i_sys_clk);
		#1 o_sclk = 1'b1;
		r = i_miso; // device drove this bit on the last fall
		repeat (4) @(posedge i_sys_clk);
		#1 o_sclk = 1'b0;
	endtask : clk_bit

	// one byte, msb first
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			clk_bit(tx[i], rx[i]);
		end
	endtask : xfer

	task automatic sel();
		@(posedge i_sys_clk);
		#1 o_cs_n = 1'b0;
	endtask : sel

	// select rises right after the last bit, then the data line stops meaning anything
	task automatic desel();
		repeat (4) @(posedge i_sys_clk);
		#1 o_cs_n = 1'b1;
		o_mosi = ~o_mosi;
	endtask : desel
endmodule : spi_host_model

// ==== bench/tb_flash_pd_id.sv ====
// self-checking bench for the power-down and id command block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
	$display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_flash_pd_id;
	localparam logic [7:0] MK = 8'h6e; // arbitrary value
	localparam logic [7:0] DV = 8'h24; // arbitrary value
	localparam logic [7:0] TY = 8'h47; // arbitrary value
	localparam logic [7:0] CP = 8'h13; // arbitrary value
	logic       sys_clk, rstn, cs_n, sclk, mosi, busy, miso, oe_n, sleep, ready;
	logic [7:0] b;
	int         n_mismatch, samples_checked, t;
	// a released output line shows the inverse of the last bit, so stale data cannot pass
	logic       miso_line;
	assign miso_line = oe_n ? ~miso : miso;

	flash_pd_id #(.MAKER_CODE(MK), .DEVICE_CODE(DV), .MEM_TYPE_CODE(TY), .CAPACITY_CODE(CP))
	flash_pd_id_inst (.i_sys_clk(sys_clk), .i_rstn(rstn), .i_cs_n(cs_n), .i_sclk(sclk),
		.i_serial_in(mosi), .i_busy(busy),
		.o_serial_out(miso), .o_serial_out_oe_n(oe_n), .o_deep_sleep(sleep), .o_ready(ready));
	spi_host_model spi_host_model_inst (.i_sys_clk(sys_clk), .o_cs_n(cs_n), .o_sclk(sclk),
		.o_mosi(mosi), .i_miso(miso_line));

	// 100 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : cyc

	// opcode then n parameter bytes, the last one carrying lastb
	task automatic hdr(input logic [7:0] op, input int n, input logic [7:0] lastb);
		spi_host_model_inst.sel();
		spi_host_model_inst.xfer(op, b);
		for (int i = 1; i <= n; i++) begin
			spi_host_model_inst.xfer((i == n) ? lastb : 8'h00, b);
		end
	endtask : hdr

	// four output bytes, then deselect; output must be released afterwards
	task automatic rd4(input logic [7:0] e0, e1, e2, e3);
		spi_host_model_inst.xfer(8'h00, b);
		`CHK("byte0", e0, b)
		spi_host_model_inst.xfer(8'h00, b);
		`CHK("byte1", e1, b)
		spi_host_model_inst.xfer(8'h00, b);
		`CHK("byte2", e2, b)
		spi_host_model_inst.xfer(8'h00, b);
		`CHK("byte3", e3, b)
		spi_host_model_inst.desel();
		cyc(2);
		`CHK("oe_n after read", 1'b1, oe_n)
		`CHK("ready after read", 1'b1, ready)
	endtask : rd4

	// bounded wait for standby
	task automatic wait_rdy(output int c);
		c = 0;
		while (ready !== 1'b1 && c < 1000) begin
			cyc(1);
			c++;
		end
	endtask : wait_rdy

	task automatic t_reset();
		`CHK("oe_n", 1'b1, oe_n)
		`CHK("sleep", 1'b0, sleep)
		`CHK("ready", 1'b1, ready)
		$display("reset values done");
	endtask : t_reset

	task automatic t_reads();
		hdr(8'h9f, 0, 8'h00);
		rd4(MK, TY, CP, MK);
		hdr(8'h90, 3, 8'h00);
		rd4(MK, DV, MK, DV);
		hdr(8'h90, 3, 8'h01);
		rd4(DV, MK, DV, MK);
		hdr(8'hab, 3, 8'h00);
		rd4(DV, DV, DV, DV);
		$display("id reads done");
	endtask : t_reads

	task automatic t_sleep();
		hdr(8'hb9, 0, 8'h00);
		spi_host_model_inst.desel();
		cyc(2);
		`CHK("ready entering", 1'b0, ready)
		cyc(280);
		`CHK("sleep early", 1'b0, sleep)
		cyc(30);
		`CHK("sleep", 1'b1, sleep)
		// a code read while asleep must stay silent
		hdr(8'h90, 3, 8'h00);
		spi_host_model_inst.xfer(8'h00, b);
		`CHK("oe_n asleep", 1'b1, oe_n)
		spi_host_model_inst.desel();
		cyc(2);
		`CHK("still asleep", 1'b1, sleep)
		hdr(8'hab, 0, 8'h00);
		spi_host_model_inst.desel();
		wait_rdy(t);
		`CHK("short wake", 1'b1, 1'(t >= 295 && t <= 310))
		`CHK("awake", 1'b0, sleep)
		hdr(8'hb9, 0, 8'h00);
		spi_host_model_inst.desel();
		cyc(320);
		hdr(8'hab, 1, 8'h00);
		spi_host_model_inst.desel();
		wait_rdy(t);
		`CHK("code wake", 1'b1, 1'(t >= 175 && t <= 190))
		// device code shifted while asleep, then the shorter code wake
		hdr(8'hb9, 0, 8'h00);
		spi_host_model_inst.desel();
		cyc(320);
		hdr(8'hab, 3, 8'h00);
		spi_host_model_inst.xfer(8'h00, b);
		`CHK("code asleep", DV, b)
		spi_host_model_inst.desel();
		wait_rdy(t);
		`CHK("code read wake", 1'b1, 1'(t >= 175 && t <= 190))
		$display("sleep and wake done");
	endtask : t_sleep

	task automatic t_no_sleep();
		hdr(8'hb9, 0, 8'h00);
		spi_host_model_inst.clk_bit(1'b0, b[0]);
		spi_host_model_inst.desel();
		spi_host_model_inst.sel();
		spi_host_model_inst.desel();
		cyc(320);
		`CHK("sleep extra bit", 1'b0, sleep)
		`CHK("ready extra bit", 1'b1, ready)
		$display("refused sleep done");
	endtask : t_no_sleep

	task automatic t_busy();
		busy = 1'b1;
		hdr(8'hb9, 0, 8'h00);
		spi_host_model_inst.desel();
		cyc(320);
		`CHK("sleep busy", 1'b0, sleep)
		hdr(8'h9f, 0, 8'h00);
		spi_host_model_inst.xfer(8'h00, b);
		`CHK("oe_n ident busy", 1'b1, oe_n)
		spi_host_model_inst.desel();
		hdr(8'hab, 3, 8'h00);
		spi_host_model_inst.xfer(8'h00, b);
		`CHK("oe_n code busy", 1'b1, oe_n)
		spi_host_model_inst.desel();
		busy = 1'b0;
		cyc(2);
		$display("busy refusals done");
	endtask : t_busy

	task automatic end_of_test();
		$display("checked %0d, mismatched %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_of_test

	// main sequence after 20 cycles of reset
	initial begin
		busy = 1'b0;
		rstn = 1'b0;
		n_mismatch = 0;
		samples_checked = 0;
		cyc(20);
		rstn = 1'b1;
		cyc(2);
		t_reset();
		t_reads();
		t_sleep();
		t_no_sleep();
		t_busy();
		end_of_test();
	end

	// the whole run needs about 6000 cycles
	initial begin
		cyc(60000);
		n_mismatch++;
		$display("watchdog expired");
		end_of_test();
	end
endmodule : tb_flash_pd_id
